// ---- design/rcs_top.sv ----
// Purpose: Clock/calendar with two polled alarms, serial slave and reset supervisor.
// Assumes: SCL, SDA, crystal and low-voltage inputs are asynchronous to clock.
// Notes:   Time is held in binary and converted to BCD on the serial port.
`timescale 1ns/100ps
`include "rcs_map.svh"
module rcs_top #(
    parameter int unsigned XDIV   = `RCS_XTAL_DIV,
    parameter int unsigned POR_C  = `RCS_POR_MS * `RCS_CYC_MS,
    parameter int unsigned WDRS_C = `RCS_WDRST_MS * `RCS_CYC_MS,
    parameter int unsigned WDL_C  = `RCS_WD_L_MS * `RCS_CYC_MS,
    parameter int unsigned WDM_C  = `RCS_WD_M_MS * `RCS_CYC_MS,
    parameter int unsigned WDS_C  = `RCS_WD_S_MS * `RCS_CYC_MS
) (
    input  wire logic                     clock,
    input  wire logic                     rst_b,
    input  wire logic                     scl_i,
    input  wire logic                     sda_i,
    output wire logic                     sda_o,
    output wire logic                     sda_oe,
    input  wire logic                     crystal_amp_input,
    output wire logic                     crystal_amp_output,
    input  wire logic                     lv_detect,
    input  wire logic [1:0]               wdt_sel,
    input  wire rcs_pkg::rcs_alarm_t [1:0] alarm_cfg,
    output wire logic                     rst_out_o,
    output wire logic                     rst_out_oe,
    output wire logic                     clock_running,
    output wire logic [1:0]               alarm_flags
);
    rcs_pkg::rcs_state_t r;
    rcs_pkg::rcs_state_t n;
    logic       scl_rise, scl_fall, sda_rise, sda_fall, start, stop;
    logic       xt_rise, tick, wr_rtc, wd_exp, rd_clr;
    logic [1:0] match, al_set;
    logic [7:0] byte_o, nptr;
    logic [6:0] dim, hw;
    logic [26:0] wd_per;

    function automatic logic [7:0] to_bcd(input logic [6:0] v);
        logic [6:0] t;
        logic [6:0] u;
        t = v / 7'h0a;
        u = v - 7'(t * 7'h0a);
        return {t[3:0], u[3:0]};
    endfunction

    function automatic logic [6:0] to_bin(input logic [7:0] b);
        return 7'({3'h0, b[7:4]} * 7'h0a) + {3'h0, b[3:0]};
    endfunction

    // Years run 2000 to 2099, so divisible by four is exact for leap years.
    function automatic logic [6:0] days_in(input logic [6:0] mo, input logic [6:0] yr);
        case (mo)
            7'h02:                      return (yr[1:0] == 2'h0) ? 7'h1d : 7'h1c;
            7'h04, 7'h06, 7'h09, 7'h0b: return 7'h1e;
            default:                    return 7'h1f;
        endcase
    endfunction

    function automatic logic [7:0] rd_byte(input rcs_pkg::rcs_time_t t, input logic [7:0] a,
                                           input logic mil, input logic [1:0] fl,
                                           input logic run);
        logic [6:0] h;
        logic [7:0] b;
        h = (t.hr >= `RCS_HR_HALF) ? t.hr - `RCS_HR_HALF : t.hr;
        if (h == 7'h00) begin
            h = `RCS_HR_HALF;
        end
        b = mil ? to_bcd(t.hr) : to_bcd(h);
        case (a)
            `RCS_A_SC:  return to_bcd(t.sec);
            `RCS_A_MN:  return to_bcd(t.min);
            `RCS_A_HR:  return mil ? {2'h2, b[5:0]} : {2'h0, t.hr >= `RCS_HR_HALF, b[4:0]};
            `RCS_A_DT:  return to_bcd(t.date);
            `RCS_A_MO:  return to_bcd(t.mon);
            `RCS_A_YR:  return to_bcd(t.yr);
            `RCS_A_DW:  return {5'h00, t.dow};
            `RCS_A_CEN: return `RCS_CEN_VAL;
            `RCS_A_SR:  return {1'h0, fl, 4'h0, ~run};
            default:    return 8'h00;
        endcase
    endfunction

    // Edges count only on the filtered copies, never on the first synchroniser stage.
    assign scl_rise = (r.scl_s[1] == r.scl_s[2]) & r.scl_s[2] & ~r.scl_f;
    assign scl_fall = (r.scl_s[1] == r.scl_s[2]) & ~r.scl_s[2] & r.scl_f;
    assign sda_rise = (r.sda_s[1] == r.sda_s[2]) & r.sda_s[2] & ~r.sda_f;
    assign sda_fall = (r.sda_s[1] == r.sda_s[2]) & ~r.sda_s[2] & r.sda_f;
    assign xt_rise  = (r.xt_s[1] == r.xt_s[2]) & r.xt_s[2] & ~r.xt_f;
    assign start    = sda_fall & r.scl_f & ~scl_fall;
    assign stop     = sda_rise & r.scl_f & ~scl_fall;
    assign tick     = r.run & xt_rise & (r.div == 15'(XDIV - 1));
    assign dim      = days_in(r.live.mon, r.live.yr);
    assign nptr     = {r.ptr[7:3], r.ptr[2:0] + 3'h1};

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_alarm
            logic [5:0] eq;
            assign eq = {r.live.dow == alarm_cfg[gi].val.dow,
                         r.live.mon == alarm_cfg[gi].val.mon,
                         r.live.date == alarm_cfg[gi].val.date,
                         r.live.hr == alarm_cfg[gi].val.hr,
                         r.live.min == alarm_cfg[gi].val.min,
                         r.live.sec == alarm_cfg[gi].val.sec};
            assign match[gi]  = (|alarm_cfg[gi].en) & (&(eq | ~alarm_cfg[gi].en));
            // Without repeat an alarm fires once until its enables are cleared.
            assign al_set[gi] = match[gi] & ~r.al_prev[gi]
                              & (alarm_cfg[gi].rpt | ~r.al_done[gi]);
        end
    endgenerate

    always_comb begin
        case (wdt_sel)
            2'h0:    wd_per = 27'(WDL_C);
            2'h1:    wd_per = 27'(WDM_C);
            2'h2:    wd_per = 27'(WDS_C);
            default: wd_per = 27'h0000000;
        endcase
    end

    always_comb begin
        n = r;
        wr_rtc = 1'h0;
        rd_clr = 1'h0;
        byte_o = 8'h00;
        hw = 7'h00;
        n.scl_s = {r.scl_s[1:0], scl_i};
        n.sda_s = {r.sda_s[1:0], sda_i};
        n.xt_s  = {r.xt_s[1:0], crystal_amp_input};
        n.lv_s  = {r.lv_s[1:0], lv_detect};
        if (r.scl_s[1] == r.scl_s[2]) n.scl_f = r.scl_s[2];
        if (r.sda_s[1] == r.sda_s[2]) n.sda_f = r.sda_s[2];
        if (r.xt_s[1] == r.xt_s[2]) n.xt_f = r.xt_s[2];
        if (r.lv_s[1] == r.lv_s[2]) n.lv_f = r.lv_s[2];
        n.xt_out = ~r.xt_f;

        // Calendar; the counters never pause for the serial port.
        if (r.run && xt_rise) begin
            n.div = tick ? 15'h0000 : r.div + 15'h0001;
        end
        if (tick) begin
            n.live.sec = r.live.sec + 7'h01;
            if (r.live.sec == `RCS_MS_MAX) begin
                n.live.sec = 7'h00;
                n.live.min = r.live.min + 7'h01;
                if (r.live.min == `RCS_MS_MAX) begin
                    n.live.min = 7'h00;
                    n.live.hr  = r.live.hr + 7'h01;
                    if (r.live.hr == `RCS_HR_MAX) begin
                        n.live.hr   = 7'h00;
                        n.live.dow  = (r.live.dow == `RCS_DW_MAX) ? 3'h0 : r.live.dow + 3'h1;
                        n.live.date = r.live.date + 7'h01;
                        if (r.live.date >= dim) begin
                            n.live.date = 7'h01;
                            n.live.mon  = r.live.mon + 7'h01;
                            if (r.live.mon == `RCS_MO_MAX) begin
                                n.live.mon = 7'h01;
                                n.live.yr  = (r.live.yr == `RCS_YR_MAX) ? 7'h00
                                                                       : r.live.yr + 7'h01;
                            end
                        end
                    end
                end
            end
        end

        // Serial slave; every bit moves on a filtered SCL edge.
        if (start) begin
            n.bus = rcs_pkg::B_ADDR;
            n.bits = 4'h0;
            n.sda_oe = 1'h0;
        end else if (stop) begin
            n.bus = rcs_pkg::B_IDLE;
            n.sda_oe = 1'h0;
        end else begin
            case (r.bus)
                rcs_pkg::B_ADDR, rcs_pkg::B_WHI, rcs_pkg::B_WLO, rcs_pkg::B_WDAT: begin
                    if (scl_rise) begin
                        n.sh = {r.sh[6:0], r.sda_f};
                        n.bits = r.bits + 4'h1;
                    end else if (scl_fall && r.bits == 4'h8) begin
                        n.sda_oe = 1'h1;
                        n.bus = rcs_pkg::rcs_bus_t'(r.bus + 4'h1);
                        if (r.bus == rcs_pkg::B_ADDR) begin
                            n.rw = r.sh[0];
                            if (r.sh[7:1] != `RCS_SLAVE) begin
                                n.sda_oe = 1'h0;
                                n.bus = rcs_pkg::B_IDLE;
                            end
                        end else if (r.bus == rcs_pkg::B_WLO) begin
                            n.ptr = r.sh;
                        end else if (r.bus == rcs_pkg::B_WDAT) begin
                            n.ptr = nptr;
                            wr_rtc = (r.ptr >= `RCS_A_SC) && (r.ptr <= `RCS_A_DW);
                            case (r.ptr)
                                `RCS_A_SC: n.live.sec = to_bin(r.sh);
                                `RCS_A_MN: n.live.min = to_bin(r.sh);
                                `RCS_A_HR: begin
                                    n.mil = r.sh[7];
                                    hw = to_bin({3'h0, r.sh[4:0]});
                                    if (hw == `RCS_HR_HALF) hw = 7'h00;
                                    if (r.sh[5]) hw = hw + `RCS_HR_HALF;
                                    n.live.hr = r.sh[7] ? to_bin({2'h0, r.sh[5:0]}) : hw;
                                end
                                `RCS_A_DT: n.live.date = to_bin(r.sh);
                                `RCS_A_MO: n.live.mon = to_bin(r.sh);
                                `RCS_A_YR: n.live.yr = to_bin(r.sh);
                                `RCS_A_DW: n.live.dow = r.sh[2:0];
                                default: ;
                            endcase
                            if (wr_rtc) begin
                                n.run = 1'h1;
                                n.div = 15'h0000;
                            end
                        end
                    end
                end
                rcs_pkg::B_AACK, rcs_pkg::B_WHACK, rcs_pkg::B_WLACK, rcs_pkg::B_WDACK: begin
                    if (scl_fall) begin
                        n.sda_oe = 1'h0;
                        n.bits = 4'h0;
                        n.bus = (r.bus == rcs_pkg::B_WDACK) ? rcs_pkg::B_WDAT
                              : rcs_pkg::rcs_bus_t'(r.bus + 4'h1);
                        if (r.bus == rcs_pkg::B_AACK && r.rw) begin
                            n.snap = r.live;
                            byte_o = rd_byte(r.live, r.ptr, r.mil, r.al_flag, r.run);
                            rd_clr = (r.ptr == `RCS_A_SR);
                            n.sh = byte_o;
                            n.sda_oe = ~byte_o[7];
                            n.bus = rcs_pkg::B_RDAT;
                        end
                    end
                end
                rcs_pkg::B_RDAT: begin
                    if (scl_rise) begin
                        n.bits = r.bits + 4'h1;
                    end else if (scl_fall) begin
                        if (r.bits == 4'h8) begin
                            n.sda_oe = 1'h0;
                            n.bus = rcs_pkg::B_RACK;
                        end else begin
                            n.sh = {r.sh[6:0], 1'h0};
                            n.sda_oe = ~r.sh[6];
                        end
                    end
                end
                rcs_pkg::B_RACK: begin
                    if (scl_rise) begin
                        n.hit = ~r.sda_f;
                    end else if (scl_fall) begin
                        n.bits = 4'h0;
                        n.bus = rcs_pkg::B_IDLE;
                        // The status section is one byte long; a further read ends the transfer.
                        if (r.hit && r.ptr != `RCS_A_SR) begin
                            n.ptr = nptr;
                            byte_o = rd_byte(r.snap, nptr, r.mil, r.al_flag, r.run);
                            n.sh = byte_o;
                            n.sda_oe = ~byte_o[7];
                            n.bus = rcs_pkg::B_RDAT;
                        end
                    end
                end
                default: n.bus = rcs_pkg::B_IDLE;
            endcase
        end

        // Alarm flags: a new match in the cycle of a status read still lands.
        n.al_prev = match;
        n.al_done = (r.al_done | al_set) & {|alarm_cfg[1].en, |alarm_cfg[0].en};
        n.al_flag = (r.al_flag & ~{2{rd_clr}}) | al_set;

        // Supervisor; the timer is kicked by every start condition.
        wd_exp = 1'h0;
        if (r.rst_oe || wd_per == 27'h0000000 || start) begin
            n.wdt = 27'h0000000;
        end else begin
            n.wdt = r.wdt + 27'h0000001;
            wd_exp = (r.wdt >= wd_per - 27'h0000001);
        end
        if (r.lv_f) begin
            n.por = 27'(POR_C);
        end else if (r.por != 27'h0000000) begin
            n.por = r.por - 27'h0000001;
        end
        if (wd_exp) begin
            n.wdh = 27'(WDRS_C);
        end else if (r.wdh != 27'h0000000) begin
            n.wdh = r.wdh - 27'h0000001;
        end
        n.rst_oe = r.lv_f | (n.por != 27'h0000000) | (n.wdh != 27'h0000000);
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            r <= '0;
            r.scl_s <= 3'h7;
            r.sda_s <= 3'h7;
            r.scl_f <= 1'h1;
            r.sda_f <= 1'h1;
            r.live.date <= 7'h01;
            r.live.mon <= 7'h01;
            r.por <= 27'(POR_C);
            r.rst_oe <= 1'h1;
        end else begin
            r <= n;
        end
    end

    assign sda_o = 1'h0;
    assign sda_oe = r.sda_oe;
    assign rst_out_o = 1'h0;
    assign rst_out_oe = r.rst_oe;
    assign crystal_amp_output = r.xt_out;
    assign clock_running = r.run;
    assign alarm_flags = r.al_flag;

    default clocking @(posedge clock); endclocking
    default disable iff (!rst_b);

    halt_until_wr_a: assert property (!r.run && !wr_rtc |=> !r.run)
        else $error("Clock started without a clock write.");
    sec_cause_a: assert property ($changed(r.live.sec) |-> $past(tick || wr_rtc))
        else $error("Seconds moved without a tick or write.");
    month_wrap_a: assert property (tick && r.live.sec == `RCS_MS_MAX && r.live.min == `RCS_MS_MAX
            && r.live.hr == `RCS_HR_MAX && r.live.date == dim && !wr_rtc
            |=> r.live.date == 7'h01)
        else $error("Date did not wrap at month end.");
    leap_day_a: assert property (tick && r.live.mon == 7'h02 && r.live.date == 7'h1c
            && r.live.yr[1:0] == 2'h0 && r.live.hr == `RCS_HR_MAX && r.live.min == `RCS_MS_MAX
            && r.live.sec == `RCS_MS_MAX && !wr_rtc |=> r.live.date == 7'h1d)
        else $error("Leap day skipped.");
    snap_take_a: assert property (r.bus == rcs_pkg::B_AACK && r.rw && scl_fall && !start && !stop
            |=> r.snap == $past(r.live) && r.bus == rcs_pkg::B_RDAT)
        else $error("Snapshot not taken at read ack.");
    live_runs_a: assert property (tick && r.bus == rcs_pkg::B_RDAT |=> r.live != $past(r.live))
        else $error("Live time stalled during read.");
    // A status read in the cycle after the set may legally clear the flag again.
    alarm_flag_a: assert property (al_set[0]
            |=> r.al_flag[0] ##1 (r.al_flag[0] || $past(rd_clr)))
        else $error("Alarm match not flagged.");
    sda_drive_a: assert property (r.sda_oe |-> r.bus inside {rcs_pkg::B_AACK, rcs_pkg::B_WHACK,
            rcs_pkg::B_WLACK, rcs_pkg::B_WDACK, rcs_pkg::B_RDAT})
        else $error("Data line driven outside ack or read bit.");
    lv_reset_a: assert property (r.lv_f |=> rst_out_oe ##1 rst_out_oe)
        else $error("Low supply did not assert reset.");
    wd_hold_a: assert property (wd_exp |=> rst_out_oe && r.wdh == 27'(WDRS_C))
        else $error("Timer expiry did not start the reset hold.");
endmodule

// ---- shared/rcs_map.svh ----
// Purpose: Offsets, slave address, limits and timing counts of the clock core.
// Assumes: 20 MHz system clock; all times are given in milliseconds.
// Notes:   Definitions only.
`ifndef RCS_MAP_SVH
`define RCS_MAP_SVH
`define RCS_CLK_HZ    20000000
`define RCS_CYC_MS    (`RCS_CLK_HZ / 1000)
`define RCS_XTAL_DIV  32768
`define RCS_POR_MS    250
`define RCS_WDRST_MS  250
`define RCS_WD_L_MS   1750
`define RCS_WD_M_MS   750
`define RCS_WD_S_MS   250
`define RCS_LONG_W    27
`define RCS_SLAVE     7'h6f
`define RCS_A_SC      8'h30
`define RCS_A_MN      8'h31
`define RCS_A_HR      8'h32
`define RCS_A_DT      8'h33
`define RCS_A_MO      8'h34
`define RCS_A_YR      8'h35
`define RCS_A_DW      8'h36
`define RCS_A_CEN     8'h37
`define RCS_A_SR      8'h3f
`define RCS_CEN_VAL   8'h20
`define RCS_MS_MAX    7'h3b
`define RCS_HR_MAX    7'h17
`define RCS_HR_HALF   7'h0c
`define RCS_MO_MAX    7'h0c
`define RCS_YR_MAX    7'h63
`define RCS_DW_MAX    3'h6
`endif

// ---- shared/rcs_pkg.sv ----
// Purpose: Types shared by the clock core.
// Assumes: Nothing beyond the map header.
// Notes:   Alarm enable bits: 0 sec, 1 min, 2 hour, 3 date, 4 month, 5 weekday.
package rcs_pkg;
    typedef enum logic [3:0] {
        B_IDLE = 4'h0, B_ADDR = 4'h1, B_AACK = 4'h2, B_WHI = 4'h3,
        B_WHACK = 4'h4, B_WLO = 4'h5, B_WLACK = 4'h6, B_WDAT = 4'h7,
        B_WDACK = 4'h8, B_RDAT = 4'h9, B_RACK = 4'ha
    } rcs_bus_t;
    typedef struct packed {
        logic [6:0] sec, min, hr, date, mon, yr;
        logic [2:0] dow;
    } rcs_time_t;
    typedef struct packed {
        rcs_time_t  val;
        logic [5:0] en;
        logic       rpt;
    } rcs_alarm_t;
    typedef struct packed {
        logic [2:0] scl_s, sda_s, xt_s, lv_s;
        logic       scl_f, sda_f, xt_f, lv_f;
        rcs_bus_t   bus;
        logic [3:0] bits;
        logic [7:0] sh, ptr;
        logic       rw, hit, sda_oe, mil, run, rst_oe, xt_out;
        rcs_time_t  live, snap;
        logic [14:0] div;
        logic [1:0] al_flag, al_done, al_prev;
        logic [26:0] por, wdt, wdh;
    } rcs_state_t;
endpackage

// ---- sim/rcs_master.sv ----
// Purpose: Serial bus master standing in for the host processor.
// Assumes: Both bus lines are pulled up; sda is the wired level of the line.
// Notes:   Missing acks on written bytes are counted in nacks.
`timescale 1ns/100ps
module rcs_master (
    input  wire logic clock,
    input  wire logic sda,
    output logic      scl,
    output logic      sda_m
);
    int nacks = 0;
    initial begin
        scl = 1'b1;
        sda_m = 1'b1;
    end
    task automatic w(input int n);
        repeat (n) @(negedge clock);
    endtask
    // Start when a is high, stop when low; the leading 28 cycles also give the bus free time.
    task automatic cond(input logic a);
        sda_m = a;
        w(28);
        scl = 1'b1;
        w(14);
        sda_m = ~a;
        w(14);
        scl = ~a;
    endtask
    // Phases of 14 cycles keep low above 1.3 us and high above 0.6 us.
    task automatic bit_x(input logic b, output logic s);
        w(14);
        sda_m = b;
        w(14);
        scl = 1'b1;
        w(7);
        s = sda;
        w(7);
        scl = 1'b0;
    endtask
    task automatic wbyte(input logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--)
            bit_x(b[i], s);
        bit_x(1'b1, s);
        if (s !== 1'b0)
            nacks++;
    endtask
    task automatic rbyte(input logic ack, output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_x(1'b1, s);
            b[i] = s;
        end
        bit_x(!ack, s);
    endtask
endmodule

// ---- sim/tb_top.sv ----
// Purpose: Self-checking bench for the clock core.
// Assumes: Four crystal edges a second and short supervisor counts.
// Notes:   Rows are BCD sec..weekday written, seconds run, bytes expected.
`timescale 1ns/100ps
module tb_top;
    // Short counts keep every supervisor phase within a few hundred cycles.
    localparam int unsigned XD  = 4;
    localparam int unsigned POR = 50;
    localparam int unsigned WRS = 40;
    localparam int unsigned WL  = 300;
    localparam int unsigned WM  = 200;
    localparam int unsigned WS  = 100;
    logic [119:0] rows [6] = '{
        120'h5959a328020001_01_00008029020002, 120'h5959a328020103_01_00008001030104,
        120'h5959a330040506_01_00008001050500, 120'h59593115061002_01_00001216061003,
        120'h5959a331129806_01_00008001019900, 120'h58598001010000_03_01008101010000};
    logic                      clock, rst_b, xtal, lv_detect;
    logic [1:0]                wdt_sel;
    rcs_pkg::rcs_alarm_t [1:0] alarm_cfg;
    logic [55:0]               q;
    int                        n_fail = 0, samples_checked = 0, cyc = 0;
    int unsigned               wd_c [3] = '{WL, WM, WS};
    wire                       scl, m_sda, sda_o, sda_oe, rst_out_o, rst_out_oe, clock_running;
    wire                       xt_out;
    wire [1:0]                 alarm_flags;
    // The line is pulled up, so it is low whenever either side pulls it.
    wire                       sda = m_sda & ~sda_oe;
    always #25 clock = ~clock;
    rcs_top #(.XDIV(XD), .POR_C(POR), .WDRS_C(WRS), .WDL_C(WL), .WDM_C(WM),
        .WDS_C(WS)) u_dut (.clock(clock), .rst_b(rst_b), .scl_i(scl), .sda_i(sda),
        .sda_o(sda_o), .sda_oe(sda_oe), .crystal_amp_input(xtal), .crystal_amp_output(xt_out),
        .lv_detect(lv_detect), .wdt_sel(wdt_sel), .alarm_cfg(alarm_cfg),
        .rst_out_o(rst_out_o), .rst_out_oe(rst_out_oe), .clock_running(clock_running),
        .alarm_flags(alarm_flags));
    rcs_master u_mst (.clock(clock), .sda(sda), .scl(scl), .sda_m(m_sda));
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
        samples_checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic rd(input logic [7:0] a, input int n, input logic [55:0] d);
        logic [7:0] b;
        u_mst.cond(1'b1);
        u_mst.wbyte(8'hde);
        u_mst.wbyte(8'h00);
        u_mst.wbyte(a);
        for (int i = 6; i >= 0 && n == 0; i--)
            u_mst.wbyte(d[8*i +: 8]);
        if (n > 0) begin
            u_mst.cond(1'b1);
            u_mst.wbyte(8'hdf);
        end
        for (int i = 0; i < n; i++) begin
            u_mst.rbyte(i < n - 1, b);
            q = {q[47:0], b};
        end
        u_mst.cond(1'b0);
    endtask
    task automatic tick(input int n);
        repeat (4 * n) begin
            xtal = 1'b1;
            repeat (4) @(negedge clock);
            xtal = 1'b0;
            repeat (4) @(negedge clock);
        end
        repeat (8) @(negedge clock);
    endtask
    task automatic wait_chk(input int n, input logic e, input string what);
        repeat (n) @(negedge clock);
        chk(rst_out_oe, e, what);
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    always @(negedge clock) begin
        cyc++;
        if (cyc == 90000) begin
            n_fail++;
            test_done();
        end
    end
    initial begin
        clock = 1'b0;
        rst_b = 1'b0;
        xtal = 1'b0;
        lv_detect = 1'b0;
        wdt_sel = 2'h3;
        alarm_cfg = '0;
        repeat (6) @(negedge clock);
        rst_b = 1'b1;
        wait_chk(40, 1'b1, "por hold");
        wait_chk(20, 1'b0, "por end");
        // The clock is still halted, so this extra crystal edge cannot move the time.
        xtal = 1'b1;
        repeat (8) @(negedge clock);
        chk(xt_out, 1'b0, "xtal out high");
        tick(2);
        chk(xt_out, 1'b1, "xtal out low");
        rd(8'h3f, 1, '0);
        chk(q[7:0], 8'h01, "halted");
        chk(clock_running, 1'b0, "running");
        foreach (rows[i]) begin
            rd(8'h30, 0, rows[i][119:64]);
            tick(int'(rows[i][63:56]));
            rd(8'h30, 7, '0);
            for (int b = 6; b >= 0; b--)
                chk(q[8*b +: 8], rows[i][8*b +: 8], "time");
            $display("row %0d done", i);
        end
        chk(clock_running, 1'b1, "running");
        alarm_cfg[0].val.sec = 7'h05;
        alarm_cfg[0].en = 6'h01;
        alarm_cfg[0].rpt = 1'b1;
        alarm_cfg[1].val.min = 7'h01;
        alarm_cfg[1].en = 6'h02;
        rd(8'h30, 0, 56'h0300a001010000);
        tick(2);
        chk(alarm_flags, 2'b01, "alarm0");
        rd(8'h3f, 1, '0);
        chk(q[7:0], 8'h20, "status");
        chk(alarm_flags, 2'b00, "cleared");
        fork
            tick(60);
            rd(8'h30, 7, '0);
        join
        chk(alarm_flags, 2'b11, "repeat");
        rd(8'h30, 2, '0);
        chk(q[15:8], 8'h05, "sec");
        chk(q[7:0], 8'h01, "min");
        $display("alarm test done");
        for (int k = 0; k < 3; k++) begin
            wdt_sel = 2'(k);
            wait_chk(int'(wd_c[k]) - 20, 1'b0, "wd quiet");
            wait_chk(40, 1'b1, "wd expiry");
            wdt_sel = 2'h3;
            wait_chk(60, 1'b0, "wd hold end");
        end
        lv_detect = 1'b1;
        wait_chk(8, 1'b1, "low supply");
        lv_detect = 1'b0;
        wait_chk(40, 1'b1, "supply back");
        wait_chk(30, 1'b0, "supply ok");
        chk(sda_o, 1'b0, "sda value");
        chk(rst_out_o, 1'b0, "reset value");
        chk(8'(u_mst.nacks), 8'h00, "acks");
        $display("supervisor test done");
        // A second loss of all power: time, flags and run state must start over.
        rst_b = 1'b0;
        repeat (6) @(negedge clock);
        chk(clock_running, 1'b0, "reset halts");
        chk(rst_out_oe, 1'b1, "reset asserts");
        chk(alarm_flags, 2'b00, "reset flags");
        rst_b = 1'b1;
        wait_chk(60, 1'b0, "por again");
        tick(2);
        rd(8'h30, 1, '0);
        chk(q[7:0], 8'h00, "halted sec");
        $display("reset test done");
        test_done();
    end
endmodule
